// file: logic/lsi_defs.vh
// Register offsets, field positions, reset values and code limits for the lane SI control block.
`ifndef LSI_DEFS_VH
`define LSI_DEFS_VH
`define LSI_LANES 8
`define LSI_NBUF 4
`define LSI_BUFW 2
`define LSI_EQW 8
`define LSI_OFF_CTRL 12'h000
`define LSI_OFF_ADAPT 12'h004
`define LSI_OFF_FIXEQ 12'h008
`define LSI_OFF_PRE 12'h00c
`define LSI_OFF_POST 12'h010
`define LSI_OFF_SWING 12'h014
`define LSI_OFF_RESTORE 12'h018
`define LSI_OFF_SAVE 12'h01c
`define LSI_OFF_ACT_ADAPT 12'h020
`define LSI_OFF_ACT_FIXEQ 12'h024
`define LSI_OFF_ACT_PRE 12'h028
`define LSI_OFF_ACT_POST 12'h02c
`define LSI_OFF_ACT_SWING 12'h030
`define LSI_OFF_RESTORED 12'h034
`define LSI_OFF_CAPS 12'h038
`define LSI_OFF_PATH 12'h03c
`define LSI_CTRL_APPLY_REINIT 0
`define LSI_CTRL_APPLY_HOT 1
`define LSI_CTRL_STAGED_SET 2
`define LSI_FIX_MAX 4'hc
`define LSI_EMPH_MAX 4'h7
`define LSI_EMPH_RSV_LO 4'h8
`define LSI_EMPH_RSV_HI 4'ha
`define LSI_SWING_MAX 4'h3
`define LSI_SWING_CUSTOM 4'hf
`define LSI_DEF_FIXEQ 4'h4
`define LSI_DEF_PRE 4'h0
`define LSI_DEF_POST 4'h2
`define LSI_DEF_SWING 4'h2
`define LSI_DEF_ADAPT 1'b1
`endif

// file: logic/lsi_code_check.v
// Per-lane code classifier for the fixed equalizer, emphasis and swing targets.
`timescale 1ns/1ps
module lsi_code_check (
    input wire [3:0] fix_in,
    input wire [3:0] pre_in,
    input wire [3:0] post_in,
    input wire [3:0] swing_in,
    input wire emph_pre_ok_in,
    output wire ok_out
);
`include "lsi_defs.vh"
    // Codes 13-15 of the fixed target are custom and accepted.
    wire fix_ok = 1'b1;
    wire pre_rsv = (pre_in >= `LSI_EMPH_RSV_LO) && (pre_in <= `LSI_EMPH_RSV_HI);
    wire post_rsv = (post_in >= `LSI_EMPH_RSV_LO) && (post_in <= `LSI_EMPH_RSV_HI);
    wire swing_rsv = (swing_in > `LSI_SWING_MAX) && (swing_in != `LSI_SWING_CUSTOM);
    // Post-only parts demand a zero pre-cursor target.
    wire pre_ok = emph_pre_ok_in | (pre_in == 4'h0);
    assign ok_out = fix_ok & ~pre_rsv & ~post_rsv & ~swing_rsv & pre_ok;
endmodule

// file: logic/lsi_eq_store.v
// Recall buffer memory holding adapted equalizer words per buffer and lane.
`timescale 1ns/1ps
module lsi_eq_store #(
    parameter NBUF = 4,
    parameter BUFW = 2,
    parameter LANES = 8,
    parameter LANEW = 3,
    parameter EQW = 8
) (
    input wire sys_clk_in,
    input wire wr_en_in,
    input wire [BUFW-1:0] wr_buf_in,
    input wire [LANEW-1:0] wr_lane_in,
    input wire [EQW-1:0] wr_data_in,
    input wire [BUFW-1:0] rd_buf_in,
    input wire [LANEW-1:0] rd_lane_in,
    output wire [EQW-1:0] rd_data_out
);
    // Each buffer has a slot for every lane, so one save never disturbs another lane.
    reg [EQW-1:0] mem [0:NBUF*LANES-1];
    always @(posedge sys_clk_in) begin
        if (wr_en_in) begin
            mem[{wr_buf_in, wr_lane_in}] <= wr_data_in;
        end
    end
    assign rd_data_out = mem[{rd_buf_in, rd_lane_in}];
endmodule

// file: logic/lsi_top.v
// APB register bank for per-lane signal integrity staging, apply and equalizer save/restore.
// What this block does
// - Override set: apply copies staged values
// - Override clear: apply loads defaults
// - Adaptive choice honoured only under override
// - Restore select processed regardless of override
// - Adaptive uses hold/save/restore; fixed uses target
// - Decode fixed equalizer target codes
// - Decode emphasis codes, reserved 8-10
// - Post-only part keeps pre-cursor zero
// - Decode swing codes, reserved 4-14
// - Advertise buffer count, per-lane storage
// - Save pauses adaptation, stores, resumes unless held
// - Ignore save when adaptation off
// - Save taken in initialized states, stored once run drops and the sweep reaches the lane
// - Show restored buffer status per lane
// - Restore loads only on apply
// - Hold clear adapts from restored; set fixes
// - Advertise support and maximum codes
// - Hot apply validates, copies, commits hardware
`timescale 1ns/1ps
module lsi_top #(
    parameter LANES = 8,
    parameter LANEW = 3,
    parameter NBUF = 4,
    parameter BUFW = 2,
    parameter EQW = 8,
    parameter FIX_SUP = 1'b1,
    parameter EMPH_SUP = 1'b1,
    parameter PRE_SUP = 1'b1,
    parameter SWING_SUP = 1'b1
) (
    input wire sys_clk_in,
    input wire rst_b_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire pready_out,
    output reg [31:0] prdata_out,
    output reg pslverr_out,
    input wire path_initialized_in,
    input wire path_activated_in,
    input wire [LANES*EQW-1:0] adapted_eq_in,
    output reg [LANES-1:0] hw_adapt_run_out,
    output reg [LANES-1:0] hw_eq_load_out,
    output reg [LANES*EQW-1:0] hw_eq_value_out,
    output reg [LANES*4-1:0] hw_fixeq_out,
    output reg [LANES*4-1:0] hw_pre_out,
    output reg [LANES*4-1:0] hw_post_out,
    output reg [LANES*4-1:0] hw_swing_out,
    output reg hw_reinit_out
);
`include "lsi_defs.vh"
    localparam ST_IDLE = 2'd0;
    localparam ST_CHECK = 2'd1;
    localparam ST_COMMIT = 2'd2;
    // Buffer count as it fits the four-bit capability field.
    localparam [3:0] NBUF4 = NBUF[3:0];

    // Two staged sets, each with override, adaptive, hold, targets and restore select.
    reg [LANES-1:0] st_over [0:1];
    reg [LANES-1:0] st_adapt [0:1];
    reg [LANES-1:0] st_hold [0:1];
    reg [LANES*4-1:0] st_fix [0:1];
    reg [LANES*4-1:0] st_pre [0:1];
    reg [LANES*4-1:0] st_post [0:1];
    reg [LANES*4-1:0] st_swing [0:1];
    reg [LANES*4-1:0] st_restore [0:1];
    reg [LANES-1:0] act_adapt;
    reg [LANES-1:0] act_hold;
    reg [LANES*4-1:0] act_fix;
    reg [LANES*4-1:0] act_pre;
    reg [LANES*4-1:0] act_post;
    reg [LANES*4-1:0] act_swing;
    reg [LANES*4-1:0] restored;
    reg [1:0] state;
    reg sel_set;
    reg hot;
    reg reject;
    reg [LANES-1:0] save_pend;
    reg [BUFW-1:0] save_buf [0:LANES-1];
    reg [LANEW-1:0] lane_ix;
    reg [LANES-1:0] load_pend;

    wire wr = psel_in & penable_in & pwrite_in;
    wire rd = psel_in & penable_in & ~pwrite_in;
    wire set_ix = pwdata_in[`LSI_CTRL_STAGED_SET];
    wire staged_addr = (paddr_in >= `LSI_OFF_ADAPT) && (paddr_in <= `LSI_OFF_RESTORE);
    wire path_ok = path_initialized_in | path_activated_in;
    assign pready_out = 1'b1;

    // Select lane i's nibble out of a packed field.
    function [3:0] nib;
        input [LANES*4-1:0] v;
        input integer i;
        begin
            nib = v[i*4 +: 4];
        end
    endfunction

    wire [LANES-1:0] lane_ok;
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_chk
            lsi_code_check u_chk (
                .fix_in(nib(st_fix[sel_set], g)),
                .pre_in(nib(st_pre[sel_set], g)),
                .post_in(nib(st_post[sel_set], g)),
                .swing_in(nib(st_swing[sel_set], g)),
                .emph_pre_ok_in(PRE_SUP),
                .ok_out(lane_ok[g])
            );
        end
    endgenerate

    // Restore nibble n+1 names buffer n, the same encoding as the save trigger.
    function [BUFW-1:0] restore_pick;
        input [LANEW-1:0] l;
        begin
            restore_pick = restored[l*4 +: BUFW] - 1'b1;
        end
    endfunction

    // One save is executed per cycle; lanes are served in a round-robin sweep.
    wire [BUFW-1:0] rd_buf = restore_pick(lane_ix);
    wire [EQW-1:0] store_q;
    // Saving waits for the lane's run output to drop, so the word is not caught mid-step.
    wire store_we = save_pend[lane_ix] & ~hw_adapt_run_out[lane_ix];
    lsi_eq_store #(
        .NBUF(NBUF), .BUFW(BUFW), .LANES(LANES), .LANEW(LANEW), .EQW(EQW)
    ) u_store (
        .sys_clk_in(sys_clk_in),
        .wr_en_in(store_we),
        .wr_buf_in(save_buf[lane_ix]),
        .wr_lane_in(lane_ix),
        .wr_data_in(adapted_eq_in[lane_ix*EQW +: EQW]),
        .rd_buf_in(rd_buf),
        .rd_lane_in(lane_ix),
        .rd_data_out(store_q)
    );

    integer i;
    always @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            for (i = 0; i < 2; i = i + 1) begin
                st_over[i] <= {LANES{1'b0}};
                st_adapt[i] <= {LANES{1'b0}};
                st_hold[i] <= {LANES{1'b0}};
                st_fix[i] <= {LANES*4{1'b0}};
                st_pre[i] <= {LANES*4{1'b0}};
                st_post[i] <= {LANES*4{1'b0}};
                st_swing[i] <= {LANES*4{1'b0}};
                st_restore[i] <= {LANES*4{1'b0}};
            end
            for (i = 0; i < LANES; i = i + 1) begin
                save_buf[i] <= {BUFW{1'b0}};
            end
            act_adapt <= {LANES{`LSI_DEF_ADAPT}};
            act_hold <= {LANES{1'b0}};
            act_fix <= {LANES{`LSI_DEF_FIXEQ}};
            act_pre <= {LANES{`LSI_DEF_PRE}};
            act_post <= {LANES{`LSI_DEF_POST}};
            act_swing <= {LANES{`LSI_DEF_SWING}};
            restored <= {LANES*4{1'b0}};
            state <= ST_IDLE;
            sel_set <= 1'b0;
            hot <= 1'b0;
            reject <= 1'b0;
            save_pend <= {LANES{1'b0}};
            lane_ix <= {LANEW{1'b0}};
            load_pend <= {LANES{1'b0}};
            hw_adapt_run_out <= {LANES{1'b0}};
            hw_eq_load_out <= {LANES{1'b0}};
            hw_eq_value_out <= {LANES*EQW{1'b0}};
            hw_fixeq_out <= {LANES*4{1'b0}};
            hw_pre_out <= {LANES*4{1'b0}};
            hw_post_out <= {LANES*4{1'b0}};
            hw_swing_out <= {LANES*4{1'b0}};
            hw_reinit_out <= 1'b0;
        end else begin
            hw_eq_load_out <= {LANES{1'b0}};
            hw_reinit_out <= 1'b0;
            lane_ix <= (lane_ix == LANES - 1) ? {LANEW{1'b0}} : lane_ix + 1'b1;
            // A save completes when the sweep reaches its lane; a new request wins the clear.
            if (store_we) begin
                save_pend[lane_ix] <= 1'b0;
            end
            if (wr && staged_addr) begin
                case (paddr_in)
                    `LSI_OFF_ADAPT: begin
                        st_over[sel_set] <= pwdata_in[LANES-1:0];
                        st_adapt[sel_set] <= pwdata_in[8 +: LANES];
                        st_hold[sel_set] <= pwdata_in[16 +: LANES];
                    end
                    `LSI_OFF_FIXEQ: st_fix[sel_set] <= pwdata_in[LANES*4-1:0];
                    `LSI_OFF_PRE: st_pre[sel_set] <= pwdata_in[LANES*4-1:0];
                    `LSI_OFF_POST: st_post[sel_set] <= pwdata_in[LANES*4-1:0];
                    `LSI_OFF_SWING: st_swing[sel_set] <= pwdata_in[LANES*4-1:0];
                    // Writing restore select only stages it; nothing moves until apply.
                    `LSI_OFF_RESTORE: st_restore[sel_set] <= pwdata_in[LANES*4-1:0];
                    default: ;
                endcase
            end
            if (wr && paddr_in == `LSI_OFF_SAVE && path_ok) begin
                for (i = 0; i < LANES; i = i + 1) begin
                    // Nibble value 0 means no request; buffer number n is written as n+1.
                    if (pwdata_in[i*4 +: 4] != 4'h0 && act_adapt[i]) begin
                        save_pend[i] <= 1'b1;
                        save_buf[i] <= pwdata_in[i*4 +: BUFW] - 1'b1;
                    end
                end
            end
            // A restored word goes out with its load pulse once the sweep reaches its lane.
            if (load_pend[lane_ix]) begin
                hw_eq_value_out[lane_ix*EQW +: EQW] <= store_q;
                hw_eq_load_out[lane_ix] <= 1'b1;
                load_pend[lane_ix] <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (wr && paddr_in == `LSI_OFF_CTRL) begin
                        sel_set <= set_ix;
                        if (pwdata_in[`LSI_CTRL_APPLY_HOT] && path_ok) begin
                            hot <= 1'b1;
                            state <= ST_CHECK;
                        end else if (pwdata_in[`LSI_CTRL_APPLY_REINIT]) begin
                            hot <= 1'b0;
                            state <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    reject <= ~&(lane_ok | ~st_over[sel_set]);
                    if (&(lane_ok | ~st_over[sel_set])) begin
                        for (i = 0; i < LANES; i = i + 1) begin
                            if (st_over[sel_set][i]) begin
                                act_adapt[i] <= st_adapt[sel_set][i];
                                act_hold[i] <= st_hold[sel_set][i];
                                act_fix[i*4 +: 4] <= nib(st_fix[sel_set], i);
                                act_pre[i*4 +: 4] <= PRE_SUP ? nib(st_pre[sel_set], i) : 4'h0;
                                act_post[i*4 +: 4] <= nib(st_post[sel_set], i);
                                act_swing[i*4 +: 4] <= nib(st_swing[sel_set], i);
                            end else begin
                                act_adapt[i] <= `LSI_DEF_ADAPT;
                                act_hold[i] <= 1'b0;
                                act_fix[i*4 +: 4] <= `LSI_DEF_FIXEQ;
                                act_pre[i*4 +: 4] <= `LSI_DEF_PRE;
                                act_post[i*4 +: 4] <= `LSI_DEF_POST;
                                act_swing[i*4 +: 4] <= `LSI_DEF_SWING;
                            end
                            // Restore select is taken whatever the override says.
                            restored[i*4 +: 4] <= nib(st_restore[sel_set], i);
                        end
                        state <= ST_COMMIT;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_COMMIT: begin
                    hw_fixeq_out <= act_fix;
                    hw_pre_out <= act_pre;
                    hw_post_out <= act_post;
                    hw_swing_out <= act_swing;
                    hw_reinit_out <= ~hot;
                    for (i = 0; i < LANES; i = i + 1) begin
                        // Restored word seeds adaptation or stands fixed per the hold bit.
                        if (act_adapt[i] && restored[i*4 +: 4] != 4'h0) begin
                            load_pend[i] <= 1'b1;
                        end
                    end
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
            for (i = 0; i < LANES; i = i + 1) begin
                // Adaptation pauses while a save is pending and stays off when held.
                hw_adapt_run_out[i] <= act_adapt[i] & ~act_hold[i] & ~save_pend[i];
            end
        end
    end

    always @* begin
        pslverr_out = 1'b0;
        case (paddr_in)
            `LSI_OFF_CTRL: prdata_out = {29'h0, reject, 1'b0, (state != ST_IDLE) | (|load_pend)};
            `LSI_OFF_ADAPT: prdata_out = {8'h0, 8'h0 | st_hold[sel_set],
                8'h0 | st_adapt[sel_set], 8'h0 | st_over[sel_set]};
            `LSI_OFF_FIXEQ: prdata_out = st_fix[sel_set];
            `LSI_OFF_PRE: prdata_out = st_pre[sel_set];
            `LSI_OFF_POST: prdata_out = st_post[sel_set];
            `LSI_OFF_SWING: prdata_out = st_swing[sel_set];
            `LSI_OFF_RESTORE: prdata_out = st_restore[sel_set];
            `LSI_OFF_SAVE: prdata_out = {24'h0, 8'h0 | save_pend};
            `LSI_OFF_ACT_ADAPT: prdata_out = {16'h0, 8'h0 | act_hold, 8'h0 | act_adapt};
            `LSI_OFF_ACT_FIXEQ: prdata_out = act_fix;
            `LSI_OFF_ACT_PRE: prdata_out = act_pre;
            `LSI_OFF_ACT_POST: prdata_out = act_post;
            `LSI_OFF_ACT_SWING: prdata_out = act_swing;
            `LSI_OFF_RESTORED: prdata_out = restored;
            `LSI_OFF_CAPS: prdata_out = {12'h0, NBUF4, `LSI_SWING_MAX, `LSI_EMPH_MAX,
                `LSI_FIX_MAX, 1'b0, SWING_SUP, EMPH_SUP, FIX_SUP};
            `LSI_OFF_PATH: prdata_out = {30'h0, path_activated_in, path_initialized_in};
            default: begin
                prdata_out = 32'h0;
                pslverr_out = psel_in & penable_in;
            end
        endcase
    end
endmodule

// file: tb/lsi_top_checker.sv
// Port-level assertions for the lane SI control block.
`timescale 1ns/1ps
module lsi_top_checker #(
    parameter LANES = 8
) (
    input wire sys_clk_in,
    input wire rst_b_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire pready_out,
    input wire [31:0] prdata_out,
    input wire pslverr_out,
    input wire path_initialized_in,
    input wire path_activated_in,
    input wire [LANES-1:0] hw_adapt_run_out,
    input wire [LANES-1:0] hw_eq_load_out,
    input wire [LANES*4-1:0] hw_fixeq_out,
    input wire [LANES*4-1:0] hw_pre_out,
    input wire [LANES*4-1:0] hw_post_out,
    input wire [LANES*4-1:0] hw_swing_out,
    input wire hw_reinit_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    wire acc = psel_in & penable_in;
    wire ctl = acc & pwrite_in & (paddr_in == 12'h000);
    wire hot = ctl & (pwdata_in[1:0] == 2'b10);
    reg [3:0] since_app;
    reg [3:0] since_save;
    // Counters start at zero in reset so the settling after release is allowed.
    always @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            since_app <= 4'h0;
            since_save <= 4'h0;
        end else begin
            since_app <= (ctl & |pwdata_in[1:0]) ? 4'h0 : since_app + {3'h0, since_app != 4'hf};
            since_save <= (acc & pwrite_in & paddr_in == 12'h01c) ? 4'h0 :
                since_save + {3'h0, since_save != 4'hf};
        end
    end
    function automatic bit rsv(input [LANES*4-1:0] e, input [LANES*4-1:0] s);
        integer i;
        rsv = 1'b0;
        for (i = 0; i < LANES; i = i + 1) begin
            if (e[4*i+:4] >= 4'h8 && e[4*i+:4] <= 4'ha) rsv = 1'b1;
            if (s[4*i+:4] >= 4'h4 && s[4*i+:4] <= 4'he) rsv = 1'b1;
        end
    endfunction
    zero_wait_a: assert property (acc |-> pready_out)
        else $error("pready low in access phase");
    unmapped_err_a: assert property (acc && paddr_in >= 12'h040 |-> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped access not refused");
    reinit_pulse_a: assert property (hw_reinit_out |=> !hw_reinit_out)
        else $error("reinit pulse too long");
    reinit_cause_a: assert property ($rose(hw_reinit_out) |-> since_app <= 4'h4)
        else $error("reinit without apply");
    hw_change_a: assert property (!$stable(hw_fixeq_out) || !$stable(hw_swing_out) |-> since_app <= 4'h4)
        else $error("targets changed without apply");
    no_reserved_a: assert property (!rsv(hw_pre_out, hw_swing_out) && !rsv(hw_post_out, 0))
        else $error("reserved code reached hardware");
    load_cause_a: assert property (|hw_eq_load_out |-> since_app <= 4'ha)
        else $error("eq load without apply");
    run_fall_a: assert property (|($past(hw_adapt_run_out) & ~hw_adapt_run_out) |-> since_save <= 4'h3 || since_app <= 4'h4)
        else $error("adaptation paused without cause");
    hot_quiet_a: assert property (hot |=> !hw_reinit_out [*5])
        else $error("hot apply pulsed reinit");
    hot_path_a: assert property (hot && !path_initialized_in && !path_activated_in |=> $stable(hw_fixeq_out) [*5])
        else $error("hot apply taken outside path states");
endmodule

// file: tb/lsi_lane_model.sv
// Lane equalizer model: each lane's adapted word drifts only while adaptation runs.
`timescale 1ns/1ps
module lsi_lane_model (
    input wire sys_clk_in,
    input wire rst_b_in,
    input wire [7:0] run_in,
    output reg [63:0] eq_out
);
    integer i;
    always @(posedge sys_clk_in) begin
        for (i = 0; i < 8; i = i + 1) begin
            if (!rst_b_in) eq_out[8*i+:8] <= 8'h10 * i;
            else if (run_in[i]) eq_out[8*i+:8] <= eq_out[8*i+:8] + 8'h01;
        end
    end
endmodule

// file: tb/lsi_top_tb_top.sv
// Self-checking testbench for the lane SI control block.
`timescale 1ns/1ps
module lsi_top_tb_top;
    reg clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pin = 1'b0, pact = 1'b0;
    reg [11:0] pa = 12'h000;
    reg [31:0] pw = 32'h0, rd;
    reg err;
    reg [7:0] sv, lv;
    wire prdy, perr, reinit;
    wire [31:0] prd, hfix, hpre, hpost, hsw;
    wire [7:0] run, load;
    wire [63:0] eqin, eqv;
    integer fails = 0, check_count = 0, cyc = 0, rcnt = 0, n;
    always #5 clk = ~clk;
    lsi_top u_lsi_top (.sys_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pw), .pready_out(prdy), .prdata_out(prd),
        .pslverr_out(perr), .path_initialized_in(pin), .path_activated_in(pact),
        .adapted_eq_in(eqin), .hw_adapt_run_out(run), .hw_eq_load_out(load),
        .hw_eq_value_out(eqv), .hw_fixeq_out(hfix), .hw_pre_out(hpre), .hw_post_out(hpost),
        .hw_swing_out(hsw), .hw_reinit_out(reinit));
    lsi_lane_model u_lsi_lane_model (.sys_clk_in(clk), .rst_b_in(rst_b), .run_in(run),
        .eq_out(eqin));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (reinit === 1'b1) rcnt <= rcnt + 1;
        if (load[2] === 1'b1) lv <= eqv[23:16];
        if (cyc == 20000) begin
            fails = fails + 1;
            final_report;
        end
    end
    task final_report;
        begin
            if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwr <= w;
            pa <= a;
            pw <= d;
            @(posedge clk);
            pen <= 1'b1;
            do begin
                @(posedge clk);
            end while (prdy !== 1'b1);
            rd = prd;
            err = perr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    task rchk(input [11:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(rd, e);
        end
    endtask
    // Polls busy so a second trigger is never dropped by the two-cycle guard.
    task apply(input [31:0] c);
        integer k;
        begin
            apb(1'b1, 12'h000, c);
            k = 0;
            do begin
                apb(1'b0, 12'h000, 32'h0);
                k = k + 1;
            end while (rd[0] !== 1'b0 && k < 10);
            repeat (2) @(posedge clk);
        end
    endtask
    task t_reset;
        begin
            rchk(12'h024, 32'h44444444);
            rchk(12'h028, 32'h00000000);
            rchk(12'h02c, 32'h22222222);
            rchk(12'h030, 32'h22222222);
            rchk(12'h038, 32'h000437c7);
            rchk(12'h040, 32'h0);
            chk({31'h0, err}, 32'h1);
        end
    endtask
    task t_override;
        begin
            apb(1'b1, 12'h004, 32'h000000ff);
            apb(1'b1, 12'h008, 32'hfdc0a951);
            apb(1'b1, 12'h00c, 32'hb7000003);
            apb(1'b1, 12'h010, 32'h0f765432);
            apb(1'b1, 12'h014, 32'hf3210f01);
            apply(32'h1);
            chk(hfix, 32'hfdc0a951);
            chk(hpre, 32'hb7000003);
            chk(hpost, 32'h0f765432);
            chk(hsw, 32'hf3210f01);
            rchk(12'h024, 32'hfdc0a951);
            chk(rcnt, 1);
            apb(1'b1, 12'h004, 32'h0000000f);
            apply(32'h1);
            chk(hfix, 32'h4444a951);
            chk(hpre, 32'h00000003);
            chk(hpost, 32'h22225432);
            chk(hsw, 32'h22220f01);
        end
    endtask
    task t_rsv(input [11:0] a, input [31:0] v, input [31:0] o);
        begin
            apb(1'b1, a, v);
            apply(32'h1);
            chk(rd[2], 1'b1);
            chk(hfix, 32'h4444a951);
            apb(1'b1, a, o);
        end
    endtask
    task t_hot;
        begin
            apb(1'b1, 12'h004, 32'h000000ff);
            apply(32'h2);
            chk(hfix, 32'h4444a951);
            apb(1'b1, 12'h000, 32'h00000004);
            rchk(12'h008, 32'h0);
            apb(1'b1, 12'h000, 32'h00000000);
            rchk(12'h008, 32'hfdc0a951);
            pact <= 1'b1;
            rchk(12'h03c, 32'h00000002);
            apply(32'h2);
            chk(hfix, 32'hfdc0a951);
            chk(rcnt, 2);
        end
    endtask
    task t_save;
        begin
            apb(1'b1, 12'h004, 32'h000004ff);
            apply(32'h2);
            chk(run, 8'h04);
            apb(1'b1, 12'h01c, 32'h00000200);
            n = 0;
            while (run[2] !== 1'b0 && n < 10) begin
                @(posedge clk);
                n = n + 1;
            end
            @(posedge clk);
            sv = eqin[23:16];
            repeat (10) @(posedge clk);
            chk(run, 8'h04);
            apb(1'b1, 12'h01c, 32'h00003000);
            rchk(12'h01c, 32'h0);
            apb(1'b1, 12'h018, 32'h00000200);
            repeat (4) @(posedge clk);
            chk(load, 8'h00);
            apb(1'b1, 12'h004, 32'h000404ff);
            apply(32'h2);
            chk(lv, sv);
            chk(run, 8'h00);
            rchk(12'h034, 32'h00000200);
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_override;
        t_rsv(12'h00c, 32'h00000008, 32'h00000003);
        t_rsv(12'h010, 32'h0f76543a, 32'h0f765432);
        t_rsv(12'h014, 32'hf3210f04, 32'hf3210f01);
        t_rsv(12'h014, 32'hf3210f0e, 32'hf3210f01);
        t_hot;
        t_save;
        final_report;
    end
endmodule
bind lsi_top lsi_top_checker #(.LANES(LANES)) u_lsi_top_checker (.sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
    .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .path_initialized_in(path_initialized_in), .path_activated_in(path_activated_in),
    .hw_adapt_run_out(hw_adapt_run_out), .hw_eq_load_out(hw_eq_load_out),
    .hw_fixeq_out(hw_fixeq_out), .hw_pre_out(hw_pre_out), .hw_post_out(hw_post_out),
    .hw_swing_out(hw_swing_out), .hw_reinit_out(hw_reinit_out));
